// ==== logic/nrcr_defs.vh ====
// Constants for the receiver configuration register group.
// Assumes byte-wide register port with 8-bit addresses and a 20 MHz clock.
`ifndef NRCR_DEFS_VH
`define NRCR_DEFS_VH

`define NRCR_ADDR_SOFD     8'h34
`define NRCR_ADDR_CTRL     8'h35
`define NRCR_ADDR_WAIT     8'h36
`define NRCR_ADDR_THRESH   8'h37
`define NRCR_ADDR_RCV      8'h38

`define NRCR_SOF_EN        5
`define NRCR_SOF_SEEN      4
`define NRCR_SUBCARRIER_IRQ_ENABLE       2
`define NRCR_SUBC_SEEN     1
`define NRCR_SUBC_LIVE     0

`define NRCR_ALLOW_BITS    7
`define NRCR_MULTI         6
`define NRCR_EMD           3
`define NRCR_WAIT_UNIT     7

`define NRCR_RST_SOFD      8'h00
`define NRCR_RST_CTRL      8'h04
`define NRCR_RST_WAIT      8'h00
`define NRCR_RST_THRESH    8'h00
`define NRCR_RST_RCV       8'h00

`define NRCR_BAUD_106      3'h4
`define NRCR_BAUD_212      3'h5
`define NRCR_BAUD_424      3'h6
`define NRCR_BAUD_847      3'h7

`define NRCR_CLK_KHZ       20000
`define NRCR_CARRIER_KHZ   13560
// Sixteen carrier periods in clk cycles, rounded down (never longer than exact), no minimum
`define NRCR_CARRIER_CYC   16
`define NRCR_UNIT16_CYC    ((`NRCR_CARRIER_CYC * `NRCR_CLK_KHZ) / `NRCR_CARRIER_KHZ)
// Half bit period at 106 kBd in clk cycles (128 carrier periods per bit at 106)
`define NRCR_HALF106_CYC   ((64 * `NRCR_CLK_KHZ) / `NRCR_CARRIER_KHZ)

`define NRCR_EMD_BYTES     3

`endif

// ==== logic/nrcr_buf2.v ====
// Two-entry buffer with valid/ready on both sides.
// Assumes single clock, synchronous active-high reset.
`timescale 1ns/1ns
module nrcr_buf2 #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge clk) begin
        if (rst || flush) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            if (do_wr) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_rd) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_wr && !do_rd) begin
                count <= count + 2'd1;
            end else if (do_rd && !do_wr) begin
                count <= count - 2'd1;
            end
        end
    end

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // nrcr_buf2

// ==== logic/nrcr_regs.v ====
// Receiver configuration and status register group with receive data path control.
// Assumes byte register port from the host interface and decoder event pulses.
`timescale 1ns/1ns
`include "nrcr_defs.vh"
module nrcr_regs (
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire reg_hit,
    input wire frame_start_det,
    input wire subcarrier_det,
    input wire send_done,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_partial_valid,
    input wire [7:0] rx_partial,
    input wire rx_checksum_on,
    input wire rx_error,
    input wire rx_frame_end,
    input wire [7:0] error_reg,
    input wire force_checksum_write,
    output wire rx_stall,
    output wire fifo_valid,
    input wire fifo_ready,
    output wire [7:0] fifo_data,
    output reg fifo_reset,
    output reg receive_frame_start_irq,
    output reg rx_complete_irq,
    output reg rx_active,
    output reg rx_ignore,
    output reg [2:0] baud_select,
    output reg baud_reserved,
    output reg [3:0] decoder_min_level,
    output reg [3:0] phase_detector_min_level,
    output reg single_input_mode,
    output reg converter_mode,
    output reg [1:0] signal_input_select,
    output reg [1:0] collision_threshold,
    output reg collision_detect_on,
    output reg [1:0] collision_strength_div
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg sof_irq_enable;
    reg sof_seen;
    reg subcarrier_irq_enable;
    reg subcarrier_seen;
    reg subcarrier_live;
    reg allow_partial_bits;
    reg multi_frame_receive;
    reg disturbance_suppress;
    reg wait_unit_select;
    reg [6:0] post_send_ignore_count;
    reg [7:0] thresh_reg;
    reg [7:0] rcv_reg;
    localparam [7:0] RST_SOFD = `NRCR_RST_SOFD;
    localparam [7:0] RST_CTRL = `NRCR_RST_CTRL;
    localparam [7:0] RST_WAIT = `NRCR_RST_WAIT;

    wire wr_sofd = reg_wr && (reg_addr == `NRCR_ADDR_SOFD);
    wire wr_ctrl = reg_wr && (reg_addr == `NRCR_ADDR_CTRL);
    wire wr_wait = reg_wr && (reg_addr == `NRCR_ADDR_WAIT);

    assign reg_hit = (reg_addr >= `NRCR_ADDR_SOFD) && (reg_addr <= `NRCR_ADDR_RCV);

    always @(posedge clk) begin
        if (rst) begin
            sof_irq_enable <= RST_SOFD[`NRCR_SOF_EN];
            subcarrier_irq_enable <= RST_SOFD[`NRCR_SUBCARRIER_IRQ_ENABLE];
            allow_partial_bits <= RST_CTRL[`NRCR_ALLOW_BITS];
            multi_frame_receive <= RST_CTRL[`NRCR_MULTI];
            disturbance_suppress <= RST_CTRL[`NRCR_EMD];
            baud_select <= RST_CTRL[2:0];
            wait_unit_select <= RST_WAIT[`NRCR_WAIT_UNIT];
            post_send_ignore_count <= RST_WAIT[6:0];
            thresh_reg <= `NRCR_RST_THRESH;
            rcv_reg <= `NRCR_RST_RCV;
        end else begin
            if (wr_sofd) begin
                sof_irq_enable <= reg_wdata[`NRCR_SOF_EN];
                subcarrier_irq_enable <= reg_wdata[`NRCR_SUBCARRIER_IRQ_ENABLE];
            end
            if (wr_ctrl) begin
                allow_partial_bits <= reg_wdata[`NRCR_ALLOW_BITS];
                multi_frame_receive <= reg_wdata[`NRCR_MULTI];
                disturbance_suppress <= reg_wdata[`NRCR_EMD];
                baud_select <= reg_wdata[2:0];
            end
            if (wr_wait) begin
                wait_unit_select <= reg_wdata[`NRCR_WAIT_UNIT];
                post_send_ignore_count <= reg_wdata[6:0];
            end
            if (reg_wr && (reg_addr == `NRCR_ADDR_THRESH)) begin
                thresh_reg <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `NRCR_ADDR_RCV)) begin
                rcv_reg <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Detection flags and interrupt
    // ------------------------------------------------------------
    wire sof_ev = frame_start_det && !rx_ignore;
    wire subc_ev = subcarrier_det && !rx_ignore;

    always @(posedge clk) begin
        if (rst) begin
            sof_seen <= 1'b0;
            subcarrier_seen <= 1'b0;
            subcarrier_live <= 1'b0;
            receive_frame_start_irq <= 1'b0;
        end else begin
            if (sof_ev) begin
                sof_seen <= 1'b1;
            end else if (wr_sofd && !reg_wdata[`NRCR_SOF_SEEN]) begin
                sof_seen <= 1'b0;
            end
            if (subc_ev) begin
                subcarrier_seen <= 1'b1;
            end else if (wr_sofd && !reg_wdata[`NRCR_SUBC_SEEN]) begin
                subcarrier_seen <= 1'b0;
            end
            subcarrier_live <= subc_ev;
            receive_frame_start_irq <= (sof_irq_enable && sof_ev) ||
                (subcarrier_irq_enable && subc_ev);
        end
    end

    // ------------------------------------------------------------
    // Post-send ignore window
    // ------------------------------------------------------------
    reg [6:0] wait_left;
    reg [7:0] unit_cnt;
    reg [7:0] unit_len;
    localparam integer UNIT16_CYC = `NRCR_UNIT16_CYC;
    localparam integer HALF106_CYC = `NRCR_HALF106_CYC;
    localparam integer HALF212_CYC = `NRCR_HALF106_CYC / 2;
    localparam integer HALF424_CYC = `NRCR_HALF106_CYC / 4;
    localparam integer HALF847_CYC = `NRCR_HALF106_CYC / 8;

    always @* begin
        if (!wait_unit_select) begin
            unit_len = UNIT16_CYC[7:0];
        end else begin
            case (baud_select)
                `NRCR_BAUD_212: unit_len = HALF212_CYC[7:0];
                `NRCR_BAUD_424: unit_len = HALF424_CYC[7:0];
                `NRCR_BAUD_847: unit_len = HALF847_CYC[7:0];
                default: unit_len = HALF106_CYC[7:0];
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wait_left <= 7'd0;
            unit_cnt <= 8'd0;
            rx_ignore <= 1'b0;
        end else if (send_done) begin
            wait_left <= post_send_ignore_count;
            unit_cnt <= 8'd1;
            rx_ignore <= (post_send_ignore_count != 7'd0);
        end else if (wait_left != 7'd0) begin
            if (unit_cnt >= unit_len) begin
                unit_cnt <= 8'd1;
                wait_left <= wait_left - 7'd1;
                rx_ignore <= (wait_left != 7'd1);
            end else begin
                unit_cnt <= unit_cnt + 8'd1;
            end
        end else begin
            rx_ignore <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive data path
    // ------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_RECV = 4'b0010;
    localparam ST_ERRB = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg [3:0] state;
    reg [1:0] byte_cnt;
    wire buf_ready;
    reg push;
    reg [7:0] push_data;
    wire in_frame = (state == ST_RECV);
    wire part_ok = rx_partial_valid && (allow_partial_bits || !rx_checksum_on);

    assign rx_stall = !buf_ready;

    always @* begin
        push = 1'b0;
        push_data = rx_byte;
        if (state == ST_ERRB) begin
            push = 1'b1;
            push_data = error_reg;
        end else if (in_frame && rx_byte_valid) begin
            push = 1'b1;
        end else if (in_frame && part_ok) begin
            push = 1'b1;
            push_data = rx_partial;
        end
    end

    // Error in first bytes, or short frame end, rejects the frame
    wire early = disturbance_suppress && (byte_cnt < `NRCR_EMD_BYTES);
    wire emd_hit = in_frame && early && (rx_error ||
        (rx_frame_end && !(rx_byte_valid && byte_cnt == 2'd2)));

    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            byte_cnt <= 2'd0;
            fifo_reset <= 1'b0;
            rx_complete_irq <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            fifo_reset <= 1'b0;
            rx_complete_irq <= 1'b0;
            case (state)
                ST_IDLE: begin
                    byte_cnt <= 2'd0;
                    if (sof_ev) begin
                        state <= ST_RECV;
                        rx_active <= 1'b1;
                    end
                end
                ST_RECV: begin
                    if (push && buf_ready && byte_cnt != 2'd3) begin
                        byte_cnt <= byte_cnt + 2'd1;
                    end
                    if (emd_hit) begin
                        fifo_reset <= 1'b1;
                        byte_cnt <= 2'd0;
                        // Rejected frames leave the receiver armed
                        rx_active <= 1'b1;
                        state <= ST_IDLE;
                    end else if (rx_frame_end) begin
                        state <= multi_frame_receive ? ST_ERRB : ST_DONE;
                    end
                end
                ST_ERRB: begin
                    if (buf_ready) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    rx_complete_irq <= 1'b1;
                    if (multi_frame_receive) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_IDLE;
                        rx_active <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Host should wait for three bytes; flush only on rejection
    nrcr_buf2 #(
        .WIDTH(8)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .flush(fifo_reset),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(push_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            baud_reserved <= 1'b0;
            decoder_min_level <= 4'h0;
            phase_detector_min_level <= 4'h0;
            single_input_mode <= 1'b0;
            converter_mode <= 1'b0;
            signal_input_select <= 2'h0;
            collision_threshold <= 2'h0;
            collision_detect_on <= 1'b1;
            collision_strength_div <= 2'h0;
        end else begin
            baud_reserved <= !baud_select[2];
            decoder_min_level <= thresh_reg[7:4];
            phase_detector_min_level <= thresh_reg[3:0];
            single_input_mode <= rcv_reg[7];
            converter_mode <= rcv_reg[6];
            signal_input_select <= rcv_reg[5:4];
            collision_threshold <= rcv_reg[1:0];
            collision_detect_on <= (rcv_reg[1:0] != 2'h3);
            collision_strength_div <= rcv_reg[1:0];
        end
    end

    // ------------------------------------------------------------
    // Read mux, reserved bits read zero
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `NRCR_ADDR_SOFD: reg_rdata <= {2'b00, sof_irq_enable, sof_seen, 1'b0,
                    subcarrier_irq_enable, subcarrier_seen, subcarrier_live};
                `NRCR_ADDR_CTRL: reg_rdata <= {allow_partial_bits, multi_frame_receive, 2'b00,
                    disturbance_suppress, baud_select};
                `NRCR_ADDR_WAIT: reg_rdata <= {wait_unit_select, post_send_ignore_count};
                `NRCR_ADDR_THRESH: reg_rdata <= thresh_reg;
                `NRCR_ADDR_RCV: reg_rdata <= rcv_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // nrcr_regs

// ==== sim/nrcr_regs_chk.sv ====
// Port-level checks for the receiver register group.
// Assumes it is bound into nrcr_regs.
`timescale 1ns/1ns
module nrcr_regs_chk (
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire frame_start_det,
    input wire subcarrier_det,
    input wire fifo_valid,
    input wire fifo_ready,
    input wire [7:0] fifo_data,
    input wire fifo_reset,
    input wire receive_frame_start_irq,
    input wire rx_complete_irq,
    input wire rx_ignore,
    input wire [2:0] baud_select,
    input wire baud_reserved,
    input wire [1:0] collision_threshold,
    input wire collision_detect_on
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    reg [7:0] sofd;
    // ---
    // Shadow of the interrupt enables
    // ---
    always @(posedge clk) begin
        if (rst)
            sofd <= 8'h00;
        else if (reg_wr && reg_addr == 8'h34)
            sofd <= reg_wdata;
    end
    sequence s_sof;
        !rx_ignore && frame_start_det && sofd[5];
    endsequence
    sequence s_subc;
        !rx_ignore && subcarrier_det && sofd[2];
    endsequence
    property p_sof_irq;
        s_sof |=> receive_frame_start_irq;
    endproperty
    a_sof_irq: assert property (p_sof_irq) else $error("sof irq missing");
    property p_subc_irq;
        s_subc |=> receive_frame_start_irq;
    endproperty
    a_subc_irq: assert property (p_subc_irq) else $error("subcarrier irq missing");
    property p_ign;
        rx_ignore |=> !receive_frame_start_irq;
    endproperty
    a_ign: assert property (p_ign) else $error("event taken while ignoring");
    property p_baud;
        baud_reserved == ($past(baud_select) < 3'h4);
    endproperty
    a_baud: assert property (p_baud) else $error("reserved baud flag wrong");
    property p_coll;
        collision_detect_on == (collision_threshold != 2'h3);
    endproperty
    a_coll: assert property (p_coll) else $error("collision enable wrong");
    property p_emd;
        fifo_reset |=> !rx_complete_irq [*2];
    endproperty
    a_emd: assert property (p_emd) else $error("complete irq on rejected frame");
    property p_hold;
        fifo_valid && !fifo_ready |=> fifo_reset || $past(fifo_reset) || (fifo_valid && $stable(fifo_data));
    endproperty
    a_hold: assert property (p_hold) else $error("stalled fifo word lost");
    property p_irq_src;
        receive_frame_start_irq |-> $past(frame_start_det) || $past(subcarrier_det);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without event");
endmodule // nrcr_regs_chk
bind nrcr_regs nrcr_regs_chk nrcr_regs_chk_i (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .frame_start_det,
    .subcarrier_det, .fifo_valid, .fifo_ready, .fifo_data, .fifo_reset, .receive_frame_start_irq, .rx_complete_irq,
    .rx_ignore, .baud_select, .baud_reserved, .collision_threshold, .collision_detect_on);

// ==== sim/nrcr_card_model.sv ====
// Card model feeding decoder events and received bytes.
// Assumes the bench calls its tasks; changes follow falling edges.
`timescale 1ns/1ns
module nrcr_card_model (
    input wire clk,
    input wire rx_stall,
    output reg frame_start_det = 1'b0,
    output reg subcarrier_det = 1'b0,
    output reg rx_byte_valid = 1'b0,
    output reg [7:0] rx_byte = 8'hA5,
    output reg rx_error = 1'b0,
    output reg rx_frame_end = 1'b0,
    output reg rx_partial_valid = 1'b0,
    output reg [7:0] rx_partial = 8'h5A
);
    reg [7:0] sent[$];
    task sof;
        @(negedge clk);
        frame_start_det = 1'b1;
        @(negedge clk);
        frame_start_det = 1'b0;
    endtask
    task subc(input reg v);
        @(negedge clk);
        subcarrier_det = v;
    endtask
    // Each byte held until the receiver stops stalling, for at most 100 cycles
    task frame(input integer n, input integer err_at, input reg part);
        integer i, k;
        sof;
        for (i = 0; i < n; i = i + 1) begin
            @(negedge clk);
            rx_byte = $urandom;
            rx_byte_valid = 1'b1;
            rx_error = (i == err_at);
            sent.push_back(rx_byte);
            for (k = 0; k < 100 && rx_stall; k = k + 1)
                @(negedge clk);
        end
        @(negedge clk);
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
        rx_error = 1'b0;
        rx_frame_end = 1'b1;
        rx_partial_valid = part;
        if (part)
            sent.push_back(rx_partial);
        @(negedge clk);
        rx_frame_end = 1'b0;
        rx_partial_valid = 1'b0;
        rx_partial = ~rx_partial;
    endtask
endmodule // nrcr_card_model

// ==== sim/tb_nfc_receiver_config_regs.sv ====
// Self-checking bench for the receiver register group.
// Assumes the design, checker bind and card model are compiled first.
`timescale 1ns/1ns
module tb_nfc_receiver_config_regs;
    reg clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send_done = 1'b0;
    reg rx_checksum_on = 1'b0, force_checksum_write = 1'b0, fifo_ready = 1'b0, drain_en = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, error_reg = 8'h00, d;
    wire [7:0] reg_rdata, rx_byte, rx_partial, fifo_data;
    wire reg_hit, frame_start_det, subcarrier_det, rx_byte_valid, rx_partial_valid, rx_error, rx_frame_end;
    wire rx_stall, fifo_valid, fifo_reset, receive_frame_start_irq, rx_complete_irq, rx_active, rx_ignore;
    wire baud_reserved, single_input_mode, converter_mode, collision_detect_on;
    wire [2:0] baud_select;
    wire [3:0] decoder_min_level, phase_detector_min_level;
    wire [1:0] signal_input_select, collision_threshold, collision_strength_div;
    integer error_cnt = 0, n_tests = 0, n_sirq = 0, n_cirq = 0, n_frst = 0, n_ign = 0, i, k;
    reg [7:0] wctl[5] = '{8'h04, 8'h04, 8'h07, 8'h05, 8'h06}, wval[5] = '{8'h02, 8'h81, 8'h83, 8'h81, 8'h82};
    reg [7:0] got[$];
    always #25 clk = ~clk;
    nrcr_regs nrcr_regs_i (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
        .frame_start_det, .subcarrier_det, .send_done, .rx_byte_valid, .rx_byte, .rx_partial_valid, .rx_partial,
        .rx_checksum_on, .rx_error, .rx_frame_end, .error_reg, .force_checksum_write, .rx_stall, .fifo_valid,
        .fifo_ready, .fifo_data, .fifo_reset, .receive_frame_start_irq, .rx_complete_irq, .rx_active, .rx_ignore,
        .baud_select, .baud_reserved, .decoder_min_level, .phase_detector_min_level, .single_input_mode,
        .converter_mode, .signal_input_select, .collision_threshold, .collision_detect_on, .collision_strength_div);
    nrcr_card_model nrcr_card_model_i (.clk, .rx_stall, .frame_start_det, .subcarrier_det, .rx_byte_valid,
        .rx_byte, .rx_error, .rx_frame_end, .rx_partial_valid, .rx_partial);
    // ---
    // Event counters, fifo sink and drain stalls
    // ---
    always @(posedge clk) begin
        n_sirq <= n_sirq + (receive_frame_start_irq === 1'b1);
        n_cirq <= n_cirq + (rx_complete_irq === 1'b1);
        n_frst <= n_frst + (fifo_reset === 1'b1);
        n_ign <= n_ign + (rx_ignore === 1'b1);
        if (fifo_valid === 1'b1 && fifo_ready === 1'b1)
            got.push_back(fifo_data);
    end
    always @(negedge clk)
        fifo_ready <= drain_en && ($urandom % 4 != 0);
    // Ignore window in clk cycles: count times unit, unit from rate if val[7] set, else 16 carrier periods
    function automatic integer ign_cycles(input [7:0] ctl, input [7:0] val);
        integer unit;
        unit = (64 * 20000 / 13560) >> ctl[1:0];
        if (!val[7])
            unit = 16 * 20000 / 13560;
        ign_cycles = val[6:0] * unit;
    endfunction
    task check(input [7:0] seen, input [7:0] exp, input string name);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rdchk(input [7:0] a, input [7:0] exp, input string name);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, exp, name);
    endtask
    task drain_cmp;
        repeat (4) @(negedge clk);
        for (k = 0; k < 400 && got.size() < nrcr_card_model_i.sent.size(); k = k + 1)
            @(negedge clk);
        if (got.size() < nrcr_card_model_i.sent.size()) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
        check(got == nrcr_card_model_i.sent, 1'b1, "fifo words");
        got.delete();
        nrcr_card_model_i.sent.delete();
    endtask
    initial begin
        d = $urandom(1);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rdchk(8'h34, 8'h00, "sofd reset");
        rdchk(8'h35, 8'h04, "receiver_control reset");
        rdchk(8'h39, 8'h00, "unmapped");
        check(reg_hit, 1'b0, "hit unmapped");
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h35, i[7:0]);
            rdchk(8'h35, i[7:0], "baud reg");
            check(baud_select, i[2:0], "baud_select");
            check(baud_reserved, i < 4, "baud reserved");
        end
        for (i = 0; i < 4; i = i + 1) begin
            d = $urandom;
            wr(8'h37, d);
            @(negedge clk);
            check(decoder_min_level, d[7:4], "min level");
            check(phase_detector_min_level, d[3:0], "phase level");
            d[5:4] = i[1:0];
            d[1:0] = i[1:0];
            wr(8'h38, d);
            rdchk(8'h38, d & 8'hF3, "rcv reg");
            check(reg_hit, 1'b1, "hit mapped");
            check({collision_threshold, collision_strength_div}, {i[1:0], i[1:0]}, "coll level");
            check({single_input_mode, converter_mode, signal_input_select}, d[7:4], "modes");
            check(collision_detect_on, i != 3, "coll on");
        end
        wr(8'h34, 8'h24);
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'h35, wctl[i]);
            wr(8'h36, wval[i]);
            @(negedge clk);
            send_done = 1'b1;
            n_ign = 0;
            @(negedge clk);
            send_done = 1'b0;
            nrcr_card_model_i.sof;
            repeat (ign_cycles(wctl[i], wval[i]) + 8) @(negedge clk);
            check(n_ign[7:0], ign_cycles(wctl[i], wval[i]), "ignore cycles");
        end
        wr(8'h36, 8'h00);
        check(n_sirq[7:0], 8'h00, "irq in ignore");
        rdchk(8'h34, 8'h24, "flag in ignore");
        nrcr_card_model_i.sof;
        rdchk(8'h34, 8'h34, "sof seen");
        check(n_sirq[7:0], 8'h01, "sof irq");
        nrcr_card_model_i.subc(1'b1);
        rdchk(8'h34, 8'h37, "subc live");
        check(n_sirq > 1, 1'b1, "subc irq");
        nrcr_card_model_i.subc(1'b0);
        rdchk(8'h34, 8'h36, "subc gone");
        wr(8'h34, 8'h24);
        rdchk(8'h34, 8'h24, "flags cleared");
        fork
            wr(8'h34, 8'h24);
            nrcr_card_model_i.sof;
        join
        rdchk(8'h34, 8'h34, "set wins");
        wr(8'h34, 8'h00);
        n_sirq = 0;
        nrcr_card_model_i.sof;
        rdchk(8'h34, 8'h10, "seen no enable");
        check(n_sirq[7:0], 8'h00, "irq disabled");
        wr(8'h35, 8'h04);
        fork
            nrcr_card_model_i.frame(4, -1, 1'b0);
            begin
                repeat (9) @(negedge clk);
                check(rx_stall, 1'b1, "buffer full");
                drain_en = 1'b1;
            end
        join
        drain_cmp;
        check(rx_active, 1'b0, "single stops");
        wr(8'h35, 8'h44);
        for (i = 0; i < 2; i = i + 1) begin
            error_reg = $urandom;
            nrcr_card_model_i.frame(3, -1, 1'b0);
            nrcr_card_model_i.sent.push_back(error_reg);
            drain_cmp;
            check(rx_active, 1'b1, "multi active");
        end
        rx_checksum_on = 1'b1;
        wr(8'h35, 8'h84);
        nrcr_card_model_i.frame(0, -1, 1'b1);
        drain_cmp;
        wr(8'h35, 8'h04);
        nrcr_card_model_i.frame(0, -1, 1'b1);
        void'(nrcr_card_model_i.sent.pop_back());
        drain_cmp;
        wr(8'h35, 8'h0C);
        drain_en = 1'b0;
        force_checksum_write = 1'b1;
        n_frst = 0;
        n_cirq = 0;
        nrcr_card_model_i.frame(2, $urandom % 2, 1'b0);
        nrcr_card_model_i.frame(2, -1, 1'b0);
        repeat (4) @(negedge clk);
        check(n_frst[7:0], 8'h02, "fifo resets");
        check(n_cirq[7:0], 8'h00, "no complete irq");
        check(fifo_valid, 1'b0, "fifo emptied");
        nrcr_card_model_i.sent.delete();
        drain_en = 1'b1;
        nrcr_card_model_i.frame(3, -1, 1'b0);
        drain_cmp;
        check(n_cirq[7:0], 8'h01, "complete irq");
        summarize;
    end
endmodule // tb_nfc_receiver_config_regs
